//--- common/pdl_pkg.sv
// package of offsets, widths and reset values for the drive-level register block
package pdl_pkg;
   localparam int PDL_WIDTH = 32;
   localparam int PDL_ADDR_W = 8;
   localparam logic [7:0] PDL_OFF_DIR = 8'h00;
   localparam logic [7:0] PDL_OFF_DIR_CLR = 8'h04;
   localparam logic [7:0] PDL_OFF_DIR_SET = 8'h08;
   localparam logic [7:0] PDL_OFF_DIR_FLIP = 8'h0c;
   localparam logic [7:0] PDL_OFF_LEVEL = 8'h10;
   localparam logic [7:0] PDL_OFF_LEVEL_CLR = 8'h14;
   localparam logic [7:0] PDL_OFF_LEVEL_SET = 8'h18;
   localparam logic [7:0] PDL_OFF_LEVEL_FLIP = 8'h1c;
   localparam logic [7:0] PDL_OFF_PULL_EN = 8'h40;
   localparam logic [7:0] PDL_OFF_GUARD = 8'h44;
   localparam logic [31:0] PDL_RST_LEVEL = 32'h0000_0000;
   localparam logic [31:0] PDL_RST_DIR = 32'h0000_0000;
   localparam logic [31:0] PDL_RST_PULL = 32'h0000_0000;
   localparam logic PDL_RST_GUARD = 1'h0;
   localparam logic [31:0] PDL_UNMAPPED = 32'h0000_0000;
endpackage

//--- logic/pdl_pin_cell.sv
// one pin: drive enable, drive level and pull selection
`timescale 1ns/1ns
`default_nettype none
module pdl_pin_cell (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic dir,
   input wire logic level,
   input wire logic pull_en,
   output logic pad_out,
   output logic pad_oe,
   output logic pull_up,
   output logic pull_down
);
   // ------------------------------------------
   // registered pin controls
   // ------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         pull_up <= 1'b0;
         pull_down <= 1'b0;
      end else begin
         pad_oe <= dir;
         pad_out <= dir & level;
         pull_up <= ~dir & pull_en & level;
         pull_down <= ~dir & pull_en & ~level;
      end
   end
endmodule
`default_nettype wire

//--- logic/pdl_port_regs.sv
// drive-level, direction and alias registers of one pin group
//
// Contract
// - direction-flip alias inverts written-one direction bits
// - drive-level register 32 bits, resets zero
// - output pins driven at drive-level bit
// - input with pull: zero pulls down, one up
// - clear and set aliases avoid read-modify-write
// - clear alias zeroes written-one bits only
// - after clear: outputs low, pulls down
// - set alias sets written-one bits only
// - after set: outputs high, pulls up
// - level alias reads return drive-level register, direction alias reads the direction register
// - direction one output, zero input
// - level-flip alias inverts written-one level bits
`timescale 1ns/1ns
`default_nettype none
module pdl_port_regs
   import pdl_pkg::*;
#(
   parameter int WIDTH = PDL_WIDTH
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [PDL_ADDR_W-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic [WIDTH-1:0] PAD_OUT,
   output logic [WIDTH-1:0] PAD_OE,
   output logic [WIDTH-1:0] PULL_UP,
   output logic [WIDTH-1:0] PULL_DOWN,
   output logic [WIDTH-1:0] DIR_STATE
);
   // ------------------------------------------
   // state
   // ------------------------------------------
   logic [WIDTH-1:0] level;
   logic [WIDTH-1:0] dir;
   logic [WIDTH-1:0] pull_en;
   logic guard;
   logic [WIDTH-1:0] wbits;
   logic wr_ok;
   logic guard_wr;

   assign wbits = WDATA[WIDTH-1:0];
   // the guard register itself stays writable, else it could never be lifted
   assign guard_wr = WR && ADDR == PDL_OFF_GUARD;
   assign wr_ok = WR && !guard;

   // ------------------------------------------
   // write guard
   // ------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         guard <= PDL_RST_GUARD;
      end else if (guard_wr) begin
         guard <= WDATA[0];
      end
   end

   // ------------------------------------------
   // drive level and its aliases
   // ------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         level <= PDL_RST_LEVEL[WIDTH-1:0];
      end else if (wr_ok) begin
         unique case (ADDR)
            PDL_OFF_LEVEL: level <= wbits;
            PDL_OFF_LEVEL_CLR: level <= level & ~wbits;
            PDL_OFF_LEVEL_SET: level <= level | wbits;
            PDL_OFF_LEVEL_FLIP: level <= level ^ wbits;
            default: level <= level;
         endcase
      end
   end

   // ------------------------------------------
   // direction and its aliases
   // ------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         dir <= PDL_RST_DIR[WIDTH-1:0];
      end else if (wr_ok) begin
         unique case (ADDR)
            PDL_OFF_DIR: dir <= wbits;
            PDL_OFF_DIR_CLR: dir <= dir & ~wbits;
            PDL_OFF_DIR_SET: dir <= dir | wbits;
            PDL_OFF_DIR_FLIP: dir <= dir ^ wbits;
            default: dir <= dir;
         endcase
      end
   end

   // ------------------------------------------
   // pull enables
   // ------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         pull_en <= PDL_RST_PULL[WIDTH-1:0];
      end else if (wr_ok && ADDR == PDL_OFF_PULL_EN) begin
         pull_en <= wbits;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         DIR_STATE <= PDL_RST_DIR[WIDTH-1:0];
      end else begin
         DIR_STATE <= dir;
      end
   end

   // ------------------------------------------
   // read port, data one cycle after the strobe
   // ------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         RDATA <= PDL_UNMAPPED;
      end else if (RD) begin
         RDATA <= PDL_UNMAPPED;
         unique case (ADDR)
            PDL_OFF_LEVEL, PDL_OFF_LEVEL_CLR, PDL_OFF_LEVEL_SET, PDL_OFF_LEVEL_FLIP:
               RDATA[WIDTH-1:0] <= level;
            PDL_OFF_DIR, PDL_OFF_DIR_CLR, PDL_OFF_DIR_SET, PDL_OFF_DIR_FLIP:
               RDATA[WIDTH-1:0] <= dir;
            PDL_OFF_PULL_EN: RDATA[WIDTH-1:0] <= pull_en;
            PDL_OFF_GUARD: RDATA[0] <= guard;
            default: RDATA <= PDL_UNMAPPED;
         endcase
      end else begin
         RDATA <= PDL_UNMAPPED;
      end
   end

   // ------------------------------------------
   // pin cells
   // ------------------------------------------
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      pdl_pin_cell u_cell (
         .CLK_SYS(CLK_SYS),
         .RST(RST),
         .dir(dir[i]),
         .level(level[i]),
         .pull_en(pull_en[i]),
         .pad_out(PAD_OUT[i]),
         .pad_oe(PAD_OE[i]),
         .pull_up(PULL_UP[i]),
         .pull_down(PULL_DOWN[i])
      );
   end

   // ------------------------------------------
   // checks
   // ------------------------------------------
   a_clear_alias: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_LEVEL_CLR) |=> level == ($past(level) & ~$past(wbits)))
      else $error("clear alias result wrong");
   a_set_alias: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_LEVEL_SET) |=> level == ($past(level) | $past(wbits)))
      else $error("set alias result wrong");
   a_flip_level: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_LEVEL_FLIP) |=> level == ($past(level) ^ $past(wbits)))
      else $error("level flip wrong");
   a_flip_dir: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_DIR_FLIP) |=> dir == ($past(dir) ^ $past(wbits)))
      else $error("direction flip wrong");
   a_guard_blocks: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && guard) |=> $stable(level) && $stable(dir))
      else $error("write went through guard");
   a_out_level: assert property (@(posedge CLK_SYS) disable iff (RST)
      1'b1 |=> PAD_OUT == ($past(dir) & $past(level)) && PAD_OE == $past(dir))
      else $error("pin drive mismatch");
   a_pull_sel: assert property (@(posedge CLK_SYS) disable iff (RST)
      1'b1 |=> PULL_UP == (~$past(dir) & $past(pull_en) & $past(level))
         && PULL_DOWN == (~$past(dir) & $past(pull_en) & ~$past(level)))
      else $error("pull select mismatch");
   a_alias_read: assert property (@(posedge CLK_SYS) disable iff (RST)
      (RD && (ADDR == PDL_OFF_LEVEL_CLR || ADDR == PDL_OFF_LEVEL_SET))
      |=> RDATA[WIDTH-1:0] == $past(level))
      else $error("alias read not level");
   a_clear_pin: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_LEVEL_CLR && WDATA[0] && dir[0]) |=> ##1 !PAD_OUT[0])
      else $error("cleared pin not low");
   a_set_pin: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_LEVEL_SET && WDATA[0] && dir[0]) |=> ##1 PAD_OUT[0])
      else $error("set pin not high");

   // ------------------------------------------
   // checks: plain writes and direction clear/set aliases
   // ------------------------------------------
   a_level_write: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_LEVEL)
      |=> level == $past(wbits))
      else $error("level write wrong");
   a_dir_write: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_DIR)
      |=> dir == $past(wbits))
      else $error("direction write wrong");
   a_dir_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_DIR_CLR)
      |=> dir == ($past(dir) & ~$past(wbits)))
      else $error("direction clear wrong");
   a_dir_set: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_DIR_SET)
      |=> dir == ($past(dir) | $past(wbits)))
      else $error("direction set wrong");
   a_pull_write: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_PULL_EN)
      |=> pull_en == $past(wbits))
      else $error("pull enable write wrong");
   a_guard_write: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && ADDR == PDL_OFF_GUARD)
      |=> guard == $past(WDATA[0]))
      else $error("guard write wrong");

   // ------------------------------------------
   // checks: untouched state
   // ------------------------------------------
   // each view may move only its own register, else one alias leaks into another
   a_level_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && ADDR != PDL_OFF_LEVEL && ADDR != PDL_OFF_LEVEL_CLR
         && ADDR != PDL_OFF_LEVEL_SET && ADDR != PDL_OFF_LEVEL_FLIP)
      |=> $stable(level))
      else $error("level moved by foreign write");
   a_dir_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && ADDR != PDL_OFF_DIR && ADDR != PDL_OFF_DIR_CLR
         && ADDR != PDL_OFF_DIR_SET && ADDR != PDL_OFF_DIR_FLIP)
      |=> $stable(dir))
      else $error("direction moved by foreign write");
   a_pull_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && ADDR != PDL_OFF_PULL_EN)
      |=> $stable(pull_en))
      else $error("pull enable moved by foreign write");
   a_guard_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && ADDR != PDL_OFF_GUARD)
      |=> $stable(guard))
      else $error("guard moved by foreign write");
   a_idle_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
      !WR
      |=> $stable(level) && $stable(dir) && $stable(pull_en) && $stable(guard))
      else $error("state moved without a write");

   // ------------------------------------------
   // checks: read port
   // ------------------------------------------
   // idle reads show zero, so a stale word never passes for a fresh one
   a_read_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
      !RD
      |=> RDATA == PDL_UNMAPPED)
      else $error("read data not cleared");
   a_read_level: assert property (@(posedge CLK_SYS) disable iff (RST)
      (RD && (ADDR == PDL_OFF_LEVEL || ADDR == PDL_OFF_LEVEL_FLIP))
      |=> RDATA[WIDTH-1:0] == $past(level))
      else $error("level read wrong");
   a_read_dir: assert property (@(posedge CLK_SYS) disable iff (RST)
      (RD && (ADDR == PDL_OFF_DIR || ADDR == PDL_OFF_DIR_CLR
         || ADDR == PDL_OFF_DIR_SET || ADDR == PDL_OFF_DIR_FLIP))
      |=> RDATA[WIDTH-1:0] == $past(dir))
      else $error("direction read wrong");
   a_read_pull: assert property (@(posedge CLK_SYS) disable iff (RST)
      (RD && ADDR == PDL_OFF_PULL_EN)
      |=> RDATA[WIDTH-1:0] == $past(pull_en))
      else $error("pull enable read wrong");
   a_read_guard: assert property (@(posedge CLK_SYS) disable iff (RST)
      (RD && ADDR == PDL_OFF_GUARD)
      |=> RDATA == {31'h0, $past(guard)})
      else $error("guard read wrong");

   // ------------------------------------------
   // checks: pin outputs
   // ------------------------------------------
   // pins settle one edge after their register, so pin checks look two edges on
   a_dir_mirror: assert property (@(posedge CLK_SYS) disable iff (RST)
      1'b1
      |=> DIR_STATE == $past(dir))
      else $error("direction copy wrong");
   a_pull_excl: assert property (@(posedge CLK_SYS) disable iff (RST)
      1'b1
      |-> (PULL_UP & PULL_DOWN) == '0)
      else $error("both pulls selected");
   a_drive_or_pull: assert property (@(posedge CLK_SYS) disable iff (RST)
      1'b1
      |-> (PAD_OE & (PULL_UP | PULL_DOWN)) == '0)
      else $error("pull on a driven pin");
   a_input_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
      1'b1
      |-> (~PAD_OE & PAD_OUT) == '0)
      else $error("input pin drives high");
   a_clear_pull: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_LEVEL_CLR && WDATA[0] && !dir[0] && pull_en[0])
      |=> ##1 PULL_DOWN[0] && !PULL_UP[0])
      else $error("cleared input not pulled down");
   a_set_pull: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_LEVEL_SET && WDATA[0] && !dir[0] && pull_en[0])
      |=> ##1 PULL_UP[0] && !PULL_DOWN[0])
      else $error("set input not pulled up");
   a_flip_pin: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_LEVEL_FLIP && WDATA[0] && dir[0])
      |=> ##1 PAD_OUT[0] != $past(level[0], 2))
      else $error("flipped pin kept its level");
   a_dir_flip_pin: assert property (@(posedge CLK_SYS) disable iff (RST)
      (WR && !guard && ADDR == PDL_OFF_DIR_FLIP && WDATA[0])
      |=> ##1 PAD_OE[0] != $past(dir[0], 2))
      else $error("flipped pin kept its direction");
endmodule
`default_nettype wire

//--- verification/pdl_port_regs_tb.sv
// self-checking bench of the drive-level register block
`timescale 1ns/1ns
`default_nettype none
module pdl_port_regs_tb
   import pdl_pkg::*;
;
   logic CLK_SYS = 1'b0;
   logic RST = 1'b1;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0000_0000;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [31:0] RDATA, PAD_OUT, PAD_OE, PULL_UP, PULL_DOWN, DIR_STATE;
   logic [31:0] m_dir = PDL_RST_DIR, m_lvl = PDL_RST_LEVEL, m_pull = PDL_RST_PULL;
   logic m_guard = PDL_RST_GUARD;
   logic [7:0] a;
   int seed = 32'h691950f1;
   int error_cnt = 0;
   int num_checks = 0;
   // 0x2c is unmapped on purpose
   logic [7:0] amap [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h40, 8'h44, 8'h2c};
   // ----------------------------------------
   // corner writes: guard on in mid-sequence, zero masks
   // ----------------------------------------
   logic [39:0] cw [15] = '{{8'h40, 32'h00ff_00ff}, {8'h08, 32'h0000_ffff}, {8'h18, 32'hffff_ffff},
      {8'h14, 32'h0f0f_00ff}, {8'h1c, 32'h3c3c_3c3c}, {8'h0c, 32'hffff_ffff}, {8'h04, 32'h0000_00ff},
      {8'h10, 32'ha5a5_a5a5}, {8'h44, 32'h0000_0001}, {8'h18, 32'hffff_ffff}, {8'h0c, 32'h0000_ffff},
      {8'h44, 32'h0000_0000}, {8'h00, 32'h1234_5678}, {8'h14, 32'h0000_0000}, {8'h18, 32'h0000_0000}};

   pdl_port_regs #(.WIDTH(PDL_WIDTH)) dut_u (
      .CLK_SYS(CLK_SYS),
      .RST(RST),
      .ADDR(ADDR),
      .WDATA(WDATA),
      .WR(WR),
      .RD(RD),
      .RDATA(RDATA),
      .PAD_OUT(PAD_OUT),
      .PAD_OE(PAD_OE),
      .PULL_UP(PULL_UP),
      .PULL_DOWN(PULL_DOWN),
      .DIR_STATE(DIR_STATE)
   );

   always #5 CLK_SYS = ~CLK_SYS;

   // ----------------------------------------
   // expectation model
   // ----------------------------------------
   function automatic logic [31:0] rd_exp(input logic [7:0] ra);
      case (ra)
         8'h00, 8'h04, 8'h08, 8'h0c: rd_exp = m_dir;
         8'h10, 8'h14, 8'h18, 8'h1c: rd_exp = m_lvl;
         8'h40: rd_exp = m_pull;
         8'h44: rd_exp = {31'h0, m_guard};
         default: rd_exp = PDL_UNMAPPED;
      endcase
   endfunction

   // the guard register itself stays writable, else it could never be lifted
   function automatic void model_wr(input logic [7:0] wa, input logic [31:0] d);
      if (wa == 8'h44) m_guard = d[0];
      else if (!m_guard) begin
         case (wa)
            8'h00: m_dir = d;
            8'h04: m_dir = m_dir & ~d;
            8'h08: m_dir = m_dir | d;
            8'h0c: m_dir = m_dir ^ d;
            8'h10: m_lvl = d;
            8'h14: m_lvl = m_lvl & ~d;
            8'h18: m_lvl = m_lvl | d;
            8'h1c: m_lvl = m_lvl ^ d;
            8'h40: m_pull = d;
            default: ;
         endcase
      end
   endfunction

   // ----------------------------------------
   // bus tasks and comparison
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] wa, input logic [31:0] d);
      @(posedge CLK_SYS);
      WR <= 1'b1;
      ADDR <= wa;
      WDATA <= d;
      @(posedge CLK_SYS);
      WR <= 1'b0;
      model_wr(wa, d);
      @(posedge CLK_SYS);
      #1;
      chk(PAD_OE, m_dir);
      chk(DIR_STATE, m_dir);
      chk(PAD_OUT, m_dir & m_lvl);
      chk(PULL_UP, ~m_dir & m_pull & m_lvl);
      chk(PULL_DOWN, ~m_dir & m_pull & ~m_lvl);
   endtask

   task automatic rd(input logic [7:0] ra);
      @(posedge CLK_SYS);
      RD <= 1'b1;
      ADDR <= ra;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1;
      chk(RDATA, rd_exp(ra));
      @(posedge CLK_SYS);
      #1;
      chk(RDATA, 32'h0000_0000);
   endtask

   task automatic finish_test;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #1000000;
      error_cnt++;
      finish_test;
   end

   initial begin
      repeat (8) @(posedge CLK_SYS);
      RST <= 1'b0;
      foreach (amap[i]) rd(amap[i]);
      foreach (cw[i]) begin
         wr(cw[i][39:32], cw[i][31:0]);
         rd(cw[i][39:32]);
         rd(amap[4 + i % 4]);
      end
      repeat (150) begin
         a = amap[$unsigned($random(seed)) % 11];
         wr(a, $random(seed));
         rd(amap[$unsigned($random(seed)) % 11]);
      end
      finish_test;
   end
endmodule
`default_nettype wire
